// [hw/adc_output_port.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - high device-address bit is always treated as zero.
// - device stays in reset mode while the active-low reset pin is low.
// - reset rising edge loads register defaults and starts calibration.
// - calibration-done low after power-up until first calibration ends, then high.
// - calibration-done stays high until hardware or soft reset restarts calibration.
// - calibration-done low in reset; held during standby or shutdown.
// - data clock phase set by phase registers, depends on post-processing and pll.
// - ddr mode carries two sample bits per output pair.
// - even-first order puts even bits in clock-high phase, odd in low phase.
// - two registers control output data polarity.
// - overrange flag is high while input overrange is detected.
// - with post-processing on, overrange leads its data by one word.
// - in i/q mode word strobe is high only for in-phase words.
// - outside i/q, positive flag is overrange, negative flag is zero.
// - i/q cmos puts overrange and word strobe on separate flag pins.
// - i/q ddr multiplexes overrange on rising, strobe on falling phase.
module adc_output_port
  import adc_port_pkg::*;
#(
  parameter int CAL_CYCLES = 4096,
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  reset_pin_n,
  input  wire logic                  addr_select_low,
  input  wire logic                  conv_clk,
  input  wire logic                  cfg_cs_n,
  input  wire adc_port_pkg::cfg_req_t cfg_req,
  output logic [7:0]                 cfg_rdata_q,
  output logic                       cfg_match_q,
  input  wire logic                  cal_restart,
  input  wire logic                  soft_reset,
  input  wire logic                  standby,
  input  wire logic                  shutdown,
  input  wire adc_port_pkg::sample_t sample_in,
  input  wire logic                  sample_valid,
  output logic                       sample_ready_q,
  output logic [SAMPLE_W-1:0]        sample_bit_q,
  output logic                       flag_pos_q,
  output logic                       flag_neg_q,
  output logic                       forwarded_data_clock_q,
  output logic                       cal_done_q
);
  import adc_port_pkg::*;

  if (FIFO_DEPTH != 2) begin : g_bad_depth
    $error("fifo depth must be 2");
  end
  if (CAL_CYCLES < 1) begin : g_bad_cal
    $error("calibration count must be positive");
  end

  // two-flop synchronisers for pins; stage 2 and its edge-detect copy are read
  logic rstn_s1_q, rstn_s2_q, rstn_prev_q;
  logic adr_s1_q, adr_s2_q;
  logic lclk_s1_q, lclk_s2_q, lclk_prev_q;
  always_ff @(posedge clk) begin
    rstn_s1_q   <= reset_pin_n;
    rstn_s2_q   <= rstn_s1_q;
    rstn_prev_q <= rstn_s2_q;
    adr_s1_q    <= addr_select_low;
    adr_s2_q    <= adr_s1_q;
    lclk_s1_q   <= conv_clk;
    lclk_s2_q   <= lclk_s1_q;
    lclk_prev_q <= lclk_s2_q;
  end

  wire in_reset  = rst | ~rstn_s2_q;
  wire rstn_rise = rstn_s2_q & ~rstn_prev_q;
  wire lclk_rise = lclk_s2_q & ~lclk_prev_q;
  wire lclk_fall = ~lclk_s2_q & lclk_prev_q;

  // device address compare; high bit is bonded low
  logic adr_hold_q;
  always_ff @(posedge clk) begin
    if (cfg_cs_n) begin
      adr_hold_q <= adr_s2_q; // host keeps it steady under chip select
    end
  end
  wire [1:0] my_addr = {ADDR_HIGH_TIE, adr_hold_q};
  wire       cfg_hit = ~cfg_cs_n & (cfg_req.dev_addr == my_addr);
  wire       cfg_wr  = cfg_hit & cfg_req.we;

  // user registers, defaults reloaded in reset mode
  logic [7:0] phase_a_q, mode_q, phase_b_q, pol_a_q, pol_b_q, phase_c_q;
  always_ff @(posedge clk) begin
    if (in_reset) begin
      phase_a_q <= RST_PHASE;
      mode_q    <= RST_MODE;
      phase_b_q <= RST_PHASE;
      pol_a_q   <= RST_POL;
      pol_b_q   <= RST_POL;
      phase_c_q <= RST_PHASE;
    end else if (cfg_wr) begin
      unique case (cfg_req.addr)
        OFF_PHASE_A: phase_a_q <= cfg_req.wdata;
        OFF_MODE:    mode_q    <= cfg_req.wdata;
        OFF_PHASE_B: phase_b_q <= cfg_req.wdata;
        OFF_POL_A:   pol_a_q   <= cfg_req.wdata;
        OFF_POL_B:   pol_b_q   <= cfg_req.wdata;
        OFF_PHASE_C: phase_c_q <= cfg_req.wdata;
        default:     ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (cfg_req.addr)
      OFF_PHASE_A: rd_mux = phase_a_q;
      OFF_MODE:    rd_mux = mode_q;
      OFF_PHASE_B: rd_mux = phase_b_q;
      OFF_POL_A:   rd_mux = pol_a_q;
      OFF_POL_B:   rd_mux = pol_b_q;
      OFF_PHASE_C: rd_mux = phase_c_q;
      default:     rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk) begin
    cfg_rdata_q <= cfg_hit ? rd_mux : 8'h00;
    cfg_match_q <= in_reset ? 1'b0 : cfg_hit;
  end

  // mode decode
  wire [1:0] out_order = mode_q[MODE_ORDER_LSB +: 2];
  wire       ddr_en    = mode_q[MODE_DDR_BIT];
  wire       iq_en     = mode_q[MODE_IQ_BIT];
  wire       pp_en     = mode_q[MODE_PP_BIT];
  wire [SAMPLE_W-1:0] pol_mask = {pol_b_q[SAMPLE_W-9:0], pol_a_q};

  // phase of the forwarded clock; pll override wins over pp choice
  wire [PHASE_W-1:0] phase_sel =
    phase_c_q[PHC_PLL_BIT] ? phase_c_q[PHC_SEL_LSB +: PHASE_W] :
    pp_en ? phase_b_q[PHASE_W-1:0] : phase_a_q[PHASE_W-1:0];

  // calibration sequencer
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYCLES - 1);
  cal_state_t       cal_q, cal_d;
  logic [CAL_W-1:0] cal_cnt_q;
  wire cal_hold  = standby | shutdown;
  wire cal_again = cal_restart | soft_reset;
  always_comb begin
    cal_d = cal_q;
    unique case (cal_q)
      CAL_RESET: cal_d = rstn_rise ? CAL_RUN : CAL_RESET;
      CAL_RUN:   if (!cal_hold && cal_cnt_q == CAL_LAST) cal_d = CAL_DONE;
      CAL_DONE:  if (cal_again) cal_d = CAL_RUN;
      default:   cal_d = CAL_RESET;
    endcase
  end
  // standby freezes the count so the pin keeps its level
  always_ff @(posedge clk) begin
    if (in_reset) begin
      cal_q     <= CAL_RESET;
      cal_cnt_q <= '0;
    end else begin
      cal_q     <= cal_d;
      if (cal_d != CAL_RUN) cal_cnt_q <= '0;
      else if (!cal_hold) cal_cnt_q <= cal_cnt_q + CAL_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (in_reset) cal_done_q <= 1'b0;
    else if (!cal_hold) cal_done_q <= (cal_d == CAL_DONE);
  end

  // two-entry sample buffer; ready drops when both slots hold words
  sample_t    fifo_mem [FIFO_DEPTH];
  logic       wr_ptr_q, rd_ptr_q;
  logic [1:0] fill_q;
  wire        fifo_empty = (fill_q == 2'h0);
  wire        fifo_full  = (fill_q == 2'h2);
  wire        push = sample_valid & ~fifo_full & ~in_reset;
  wire        pop  = lclk_rise & ~fifo_empty & ~in_reset;
  always_ff @(posedge clk) begin
    if (push) fifo_mem[wr_ptr_q] <= sample_in;
  end
  always_ff @(posedge clk) begin
    if (in_reset) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q   <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      fill_q   <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    sample_ready_q <= ~in_reset & (fill_q + {1'b0, push} - {1'b0, pop} != 2'h2);
  end

  // word on the port; with pp, data trails its overrange by one word
  sample_t head, word_q, pp_q;
  logic    ovr_q;
  assign head = fifo_mem[rd_ptr_q];
  always_ff @(posedge clk) begin
    if (in_reset) begin
      word_q <= '0;
      pp_q   <= '0;
      ovr_q  <= 1'b0;
    end else if (pop) begin
      pp_q   <= head;
      word_q <= pp_en ? pp_q : head;
      ovr_q  <= head.overrange_flag;
    end
  end

  // ddr halves: high phase carries the first half per order
  wire [SAMPLE_W-1:0] inv_bits = word_q.bits ^ pol_mask;
  logic [PAIRS-1:0] even_bits, odd_bits;
  always_comb begin
    for (int i = 0; i < PAIRS; i++) begin
      even_bits[i] = inv_bits[2*i];
      odd_bits[i]  = inv_bits[2*i+1];
    end
  end
  wire even_first = (out_order == ORDER_EVEN_FIRST);
  wire [PAIRS-1:0] hi_half = even_first ? even_bits : odd_bits;
  wire [PAIRS-1:0] lo_half = even_first ? odd_bits : even_bits;
  wire [SAMPLE_W-1:0] ddr_word =
    {{(SAMPLE_W-PAIRS){1'b0}}, lclk_s2_q ? hi_half : lo_half};
  wire [SAMPLE_W-1:0] port_d = ddr_en ? ddr_word : inv_bits;

  // flag pins
  wire iq_word_strobe     = iq_en & word_q.is_i;
  wire pos_d   = (iq_en && ddr_en) ? (lclk_s2_q ? ovr_q : iq_word_strobe) : ovr_q;
  wire neg_d   = !iq_en ? 1'b0 : ddr_en ? ~pos_d : iq_word_strobe;

  // forwarded clock lags data by one cycle more than the chosen phase
  logic [3:0] lvl_pipe_q;
  always_ff @(posedge clk) begin
    if (in_reset) lvl_pipe_q <= 4'h0;
    else lvl_pipe_q <= {lvl_pipe_q[2:0], lclk_s2_q};
  end

  // registered port outputs, quiet in reset mode
  always_ff @(posedge clk) begin
    if (in_reset) begin
      sample_bit_q           <= '0;
      flag_pos_q             <= 1'b0;
      flag_neg_q             <= 1'b0;
      forwarded_data_clock_q <= 1'b0;
    end else begin
      sample_bit_q           <= port_d;
      flag_pos_q             <= pos_d;
      flag_neg_q             <= neg_d;
      forwarded_data_clock_q <= lvl_pipe_q[phase_sel];
    end
  end

  // checks
  a_cal_low_reset: assert property (@(posedge clk)
    $past(in_reset) |-> !cal_done_q)
    else $error("cal done high in reset");
  a_cal_hold_standby: assert property (@(posedge clk) disable iff (in_reset)
    $past(cal_hold) && !$past(in_reset) |-> $stable(cal_done_q))
    else $error("cal done moved in standby");
  a_cal_restart_low: assert property (@(posedge clk) disable iff (in_reset)
    cal_q == CAL_DONE && cal_again && !cal_hold |=> !cal_done_q)
    else $error("cal done not dropped on restart");
  a_cal_start_edge: assert property (@(posedge clk) disable iff (rst)
    rstn_rise |=> cal_q == CAL_RUN && mode_q == RST_MODE)
    else $error("calibration not started at reset release");
  a_addr_high_zero: assert property (@(posedge clk) disable iff (in_reset)
    !cfg_cs_n && cfg_req.dev_addr[1] |=> !cfg_match_q)
    else $error("high address bit matched");
  a_neg_flag_zero: assert property (@(posedge clk) disable iff (in_reset)
    !iq_en ##1 !$past(in_reset) |-> !flag_neg_q)
    else $error("negative flag not zero");
  a_ddr_even_high: assert property (@(posedge clk) disable iff (in_reset)
    ddr_en && even_first && lclk_s2_q |=> sample_bit_q[0] == $past(inv_bits[0]))
    else $error("even bit missing in high phase");
  a_iq_ddr_mux: assert property (@(posedge clk) disable iff (in_reset)
    iq_en && ddr_en && !lclk_s2_q |=> flag_pos_q == $past(iq_word_strobe))
    else $error("strobe missing in low phase");
  a_fifo_bound: assert property (@(posedge clk) disable iff (in_reset)
    fifo_full |-> !push ##1 fill_q != 2'h3)
    else $error("buffer overfilled");

  // reset mode, register defaults and write address match
  a_regs_default: assert property (@(posedge clk)
    $past(in_reset) |-> mode_q == RST_MODE && pol_a_q == RST_POL && pol_b_q == RST_POL)
    else $error("register not at default after reset");

  a_stay_reset: assert property (@(posedge clk)
    in_reset |=> cal_q == CAL_RESET)
    else $error("calibration left reset state in reset mode");

  a_mode_needs_hit: assert property (@(posedge clk) disable iff (in_reset)
    !cfg_hit |=> $stable(mode_q))
    else $error("mode written without address match");

  // calibration-done pin
  a_cal_rise_done: assert property (@(posedge clk) disable iff (in_reset)
    $rose(cal_done_q) |-> cal_q == CAL_DONE)
    else $error("cal done rose before calibration ended");

  a_cal_done_stays: assert property (@(posedge clk) disable iff (in_reset)
    cal_done_q && cal_q == CAL_DONE && !cal_again |=> cal_done_q)
    else $error("cal done dropped without restart");

  // flag pins per mode
  a_ovr_pos_noniq: assert property (@(posedge clk) disable iff (in_reset)
    !iq_en |=> flag_pos_q == $past(ovr_q))
    else $error("positive flag not overrange");

  a_cmos_strobe: assert property (@(posedge clk) disable iff (in_reset)
    iq_en && !ddr_en |=> flag_neg_q == $past(iq_word_strobe) && flag_pos_q == $past(ovr_q))
    else $error("cmos flags not split");

  a_ddr_rise_ovr: assert property (@(posedge clk) disable iff (in_reset)
    iq_en && ddr_en && lclk_s2_q |=> flag_pos_q == $past(ovr_q) && flag_neg_q == !$past(ovr_q))
    else $error("overrange missing in high phase");

  // data path
  a_ddr_upper_zero: assert property (@(posedge clk) disable iff (in_reset)
    ddr_en |=> sample_bit_q[SAMPLE_W-1:PAIRS] == '0)
    else $error("unused ddr pins not zero");

  a_pp_ovr_lead: assert property (@(posedge clk) disable iff (in_reset)
    pop && pp_en |=> word_q == $past(pp_q) && ovr_q == $past(head.overrange_flag))
    else $error("overrange not leading data");

  a_fclk_phase: assert property (@(posedge clk) disable iff (in_reset)
    !$past(in_reset) |-> forwarded_data_clock_q == $past(lvl_pipe_q[phase_sel]))
    else $error("forwarded clock phase wrong");

  a_ready_room: assert property (@(posedge clk) disable iff (in_reset)
    !$past(in_reset) |-> sample_ready_q == (fill_q != 2'h2))
    else $error("ready disagrees with buffer fill");
endmodule // adc_output_port
`default_nettype wire

// [hw/adc_port_pkg.sv]
package adc_port_pkg;
  // register offsets of the serial control port
  localparam logic [7:0] OFF_PHASE_A  = 8'h52;
  localparam logic [7:0] OFF_MODE     = 8'h62;
  localparam logic [7:0] OFF_PHASE_B  = 8'h64;
  localparam logic [7:0] OFF_POL_A    = 8'h65;
  localparam logic [7:0] OFF_POL_B    = 8'h68;
  localparam logic [7:0] OFF_PHASE_C  = 8'h6D;
  // reset values
  localparam logic [7:0] RST_PHASE    = 8'h00;
  localparam logic [7:0] RST_MODE     = 8'h04;
  localparam logic [7:0] RST_POL      = 8'h00;
  // output_mode_config fields
  localparam int MODE_ORDER_LSB = 0;
  localparam int MODE_DDR_BIT   = 2;
  localparam int MODE_IQ_BIT    = 3;
  localparam int MODE_PP_BIT    = 4;
  localparam logic [1:0] ORDER_EVEN_FIRST = 2'h0;
  // clock_phase_control_c fields
  localparam int PHC_PLL_BIT = 0;
  localparam int PHC_SEL_LSB = 1;
  // device address bit tied low
  localparam logic ADDR_HIGH_TIE = 1'b0;
  localparam int SAMPLE_W = 14;
  localparam int PAIRS    = SAMPLE_W / 2;
  localparam int PHASE_W  = 2;

  typedef struct packed {
    logic                overrange_flag;
    logic                is_i;
    logic [SAMPLE_W-1:0] bits;
  } sample_t;

  typedef struct packed {
    logic                we;
    logic [1:0]          dev_addr;
    logic [7:0]          addr;
    logic [7:0]          wdata;
  } cfg_req_t;

  typedef enum logic [1:0] {
    CAL_RESET = 2'b00,
    CAL_RUN   = 2'b01,
    CAL_DONE  = 2'b11
  } cal_state_t;
endpackage

// [dv/ddr_capture_model.sv]
`timescale 1ns/100ps
`default_nettype none
// far-side capture: rebuilds each ddr word from its two clock phases
module ddr_capture_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [13:0] pins,
  input  wire logic        flag_pos,
  input  wire logic        flag_neg,
  input  wire logic        fclk,
  output logic             cap_valid,
  output logic [16:0]      cap
);
  logic       fclk_q;
  logic [6:0] even_q;
  logic [1:0] rflag_q;
  // sampled one clk after each forwarded edge, so the data half has settled
  always_ff @(posedge clk) begin
    fclk_q    <= rst ? 1'b0 : fclk;
    cap_valid <= 1'b0;
    if (!rst && fclk && !fclk_q) begin
      even_q  <= pins[6:0];
      rflag_q <= {flag_pos, flag_neg};
    end else if (!rst && !fclk && fclk_q) begin
      cap_valid <= 1'b1;
      for (int i = 0; i < 7; i++) begin
        cap[2*i]   <= even_q[i];
        cap[2*i+1] <= pins[i];
      end
      cap[16:14] <= {rflag_q, flag_pos};
    end
  end
endmodule // ddr_capture_model
`default_nettype wire

// [dv/adc_output_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_output_port_test;
  import adc_port_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                reset_pin_n = 1'b0;
  logic                addr_select_low = 1'b1;
  logic                conv_clk = 1'b0;
  logic                cfg_cs_n = 1'b1;
  cfg_req_t            cfg_req = '0;
  logic                cal_restart = 1'b0;
  logic                soft_reset = 1'b0;
  logic                standby = 1'b0;
  sample_t             sample_in = '0;
  logic                sample_valid = 1'b0;
  logic [7:0]          cfg_rdata_q;
  logic                cfg_match_q, sample_ready_q, flag_pos_q, flag_neg_q;
  logic                forwarded_data_clock_q, cal_done_q, cap_valid;
  logic [SAMPLE_W-1:0] sample_bit_q;
  logic [16:0]         cap;
  logic [16:0]         got[$];
  int                  err_total = 0;
  int                  checks = 0;
  int                  cycles = 0;
  adc_output_port #(.CAL_CYCLES(8), .FIFO_DEPTH(2)) i_adc_output_port (
    .clk, .rst, .reset_pin_n, .addr_select_low, .conv_clk, .cfg_cs_n, .cfg_req,
    .cfg_rdata_q, .cfg_match_q, .cal_restart, .soft_reset, .standby, .shutdown(1'b0),
    .sample_in, .sample_valid, .sample_ready_q, .sample_bit_q, .flag_pos_q,
    .flag_neg_q, .forwarded_data_clock_q, .cal_done_q);
  ddr_capture_model i_ddr_capture_model (.clk, .rst, .pins(sample_bit_q),
    .flag_pos(flag_pos_q), .flag_neg(flag_neg_q), .fclk(forwarded_data_clock_q),
    .cap_valid, .cap);
  always #12.5 clk = ~clk;
  // link clock offset so its edges fall between clk edges, at a fixed phase to clk
  initial #7 forever #100 conv_clk = ~conv_clk;
  // collect words, and cut a hang short
  always @(posedge clk) begin
    if (cap_valid) got.push_back(cap);
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one control request, answer taken the cycle after
  task automatic cfg(input logic we, input logic [1:0] dev, input logic [7:0] a,
                     input logic [7:0] wd, output logic [16:0] ans);
    @(negedge clk);
    cfg_cs_n = 1'b0;
    cfg_req = '{we: we, dev_addr: dev, addr: a, wdata: wd};
    @(negedge clk);
    ans = {8'h0, cfg_match_q, cfg_rdata_q};
    cfg_cs_n = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [16:0] ans;
    cfg(1'b1, 2'b01, a, d, ans);
  endtask
  // flag must be low now and high within 40 clk cycles
  task automatic wait_cal();
    check({16'h0, cal_done_q}, 17'h0);
    for (int n = 0; n < 40 && cal_done_q !== 1'b1; n++) @(negedge clk);
    check({16'h0, cal_done_q}, 17'h1);
  endtask
  // defaults, read back, refused device address and a hole in the map
  task automatic t_regs();
    logic [16:0] ans;
    logic [7:0]  offs[6] = '{OFF_PHASE_A, OFF_MODE, OFF_PHASE_B, OFF_POL_A, OFF_POL_B,
                             OFF_PHASE_C};
    foreach (offs[i]) begin
      cfg(1'b0, 2'b01, offs[i], 8'h00, ans);
      check(ans, {9'h1, (offs[i] == OFF_MODE) ? RST_MODE : RST_PHASE});
      wr(offs[i], 8'h5A);
      cfg(1'b0, 2'b01, offs[i], 8'h00, ans);
      check(ans, 17'h15A);
    end
    cfg(1'b1, 2'b11, OFF_MODE, 8'h00, ans);
    check(ans, 17'h0);
    cfg(1'b0, 2'b00, OFF_MODE, 8'h00, ans);
    check(ans, 17'h0);
    cfg(1'b0, 2'b01, 8'h63, 8'h00, ans);
    check(ans, 17'h100);
    cfg(1'b0, 2'b01, OFF_MODE, 8'h00, ans);
    check(ans, 17'h15A);
  endtask
  // reset pin low forces the flag low; rising edge reloads defaults
  task automatic t_reset_pin();
    logic [16:0] ans;
    reset_pin_n = 1'b0;
    repeat (20) @(negedge clk);
    check({16'h0, cal_done_q}, 17'h0);
    reset_pin_n = 1'b1;
    repeat (3) @(negedge clk);
    wait_cal();
    cfg(1'b0, 2'b01, OFF_MODE, 8'h00, ans);
    check(ans, {9'h1, RST_MODE});
  endtask
  // hardware and soft restarts, then standby holding the flag
  task automatic t_cal();
    for (int hw = 0; hw < 3; hw++) begin
      check({16'h0, cal_done_q}, 17'h1);
      standby = (hw == 2);
      @(negedge clk);
      {cal_restart, soft_reset} = (hw == 0) ? 2'b01 : 2'b10;
      @(negedge clk);
      {cal_restart, soft_reset} = 2'b00;
      repeat (3) @(negedge clk);
      if (hw < 2) wait_cal();
    end
    check({16'h0, cal_done_q}, 17'h1);
    standby = 1'b0;
    repeat (40) @(negedge clk);
    check({16'h0, cal_done_q}, 17'h1);
  endtask
  // pushes outrun the link, so the buffer stalls; every word must arrive, bar the last one with pp
  task automatic t_stream(input logic [7:0] mode, input logic [7:0] pol,
                          input logic [13:0] base);
    logic [16:0] exp[6];
    sample_t     s;
    int          idx;
    logic        full_seen;
    logic        o;
    int          nw;
    nw = mode[4] ? 5 : 6; // pp never shows the last word's data
    wr(OFF_MODE, mode);
    wr(OFF_POL_A, pol);
    wr(OFF_POL_B, pol & 8'h3F);
    repeat (40) @(negedge clk);
    got.delete();
    full_seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      s = '{overrange_flag: i[0], is_i: i[1], bits: base + 14'(i * 'h911)};
      o = i[0] ^ mode[4]; // pp shows the next word's overrange
      exp[i] = {o, mode[3] & ~o, s.is_i & mode[3], s.bits ^ {pol[5:0], pol}};
      // ready seen at the falling edge promises room at the next rising edge
      while (sample_ready_q !== 1'b1) begin
        full_seen = 1'b1;
        @(negedge clk);
      end
      sample_valid = 1'b1;
      sample_in = s;
      @(negedge clk);
    end
    sample_valid = 1'b0;
    repeat (100) @(negedge clk);
    idx = -1;
    foreach (got[j]) if (idx < 0 && got[j][13:0] === exp[0][13:0]) idx = j;
    if (idx < 0 || idx + nw > got.size()) check(17'h0, exp[0]);
    else for (int k = 0; k < nw; k++)
      check(got[idx+k] & (mode[3] ? 17'h1FFFF : 17'h1BFFF), exp[k]);
    check({15'h0, full_seen, sample_ready_q}, 17'h3);
  endtask
  // cmos: whole word on the pins; with i/q the flags split across the pair
  task automatic t_cmos(input logic [7:0] mode);
    wr(OFF_MODE, mode);
    @(negedge clk);
    sample_valid = 1'b1;
    sample_in = '{overrange_flag: 1'b1, is_i: 1'b1, bits: 14'h2A5C};
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (40) @(negedge clk);
    check({3'h0, sample_bit_q}, 17'h02A5C);
    check({15'h0, flag_pos_q, flag_neg_q}, {15'h1, mode[3]});
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    reset_pin_n = 1'b1;
    repeat (3) @(negedge clk);
    wait_cal();
    t_regs();
    t_reset_pin();
    t_cal();
    t_stream(8'h04, 8'hFF, 14'h0123);
    t_stream(8'h0C, 8'h00, 14'h2345);
    t_stream(8'h1C, 8'h00, 14'h1357);
    t_cmos(8'h08);
    t_cmos(8'h00);
    finish_test();
  end
endmodule // adc_output_port_test
`default_nettype wire
